//--- verilog/cvp_pkg.sv
// Constants for the calibration vector port and trim register bank.
// Assumes a 32-bit APB slave with one register per aligned word.
package cvp_pkg;

    //////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    //////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_PORT_EN = 8'h70;
    localparam logic [7:0] IDX_VEC = 8'h71;
    localparam logic [7:0] IDX_STATUS = 8'h72;
    localparam logic [7:0] IDX_MODE = 8'h73;
    localparam logic [7:0] IDX_GAIN_A = 8'h7A;
    localparam logic [7:0] IDX_GAIN_B = 8'h7B;
    localparam logic [7:0] IDX_BANDGAP = 8'h7C;
    localparam logic [7:0] IDX_TERM_A = 8'h7E;
    localparam logic [7:0] IDX_TERM_B = 8'h7F;

    //////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PORT_EN_BIT = 0;
    localparam int BG_FIELD_W = 4;
    localparam int STAT_HALTED_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int MODE_LP_BIT = 0;
    localparam int MODE_BG_BIT = 1;

    //////////////////////////////////////////////////////////////////////
    // Reset values and sizes
    localparam logic [7:0] PORT_EN_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] VEC_RST = 8'h00;
    localparam int VEC_LEN = 673;
    localparam int VEC_IDX_W = 10;
    localparam int FIFO_DEPTH = 8;

endpackage

//--- verilog/cvp_stream_if.sv
// Valid/ready byte stream between the bank and its write FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface cvp_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- verilog/cvp_fifo.sv
// Synchronous FIFO held in flip-flops, width and depth as parameters.
// Assumes single clock and synchronous active-high reset.
`timescale 1ns/1ns
module cvp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    cvp_stream_if.snk wr,
    // Drain side
    cvp_stream_if.src rd
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CFULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] count;
    } cvp_fifo_state_t;

    cvp_fifo_state_t s_r;
    cvp_fifo_state_t s_nxt;
    logic push;
    logic pop;

    //////////////////////////////////////////////////////////////////////
    // Handshakes
    assign wr.ready = (s_r.count != CFULL);
    assign rd.valid = (s_r.count != '0);
    assign rd.data = s_r.mem[s_r.rp];
    assign push = wr.valid & wr.ready;
    assign pop = rd.valid & rd.ready;

    //////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = wr.data;
            s_nxt.wp = (s_r.wp == PLAST) ? '0 : s_r.wp + 1'b1;
        end
        if (pop)
        begin
            s_nxt.rp = (s_r.rp == PLAST) ? '0 : s_r.rp + 1'b1;
        end
        if (push && !pop)
        begin
            s_nxt.count = s_r.count + 1'b1;
        end
        else if (pop && !push)
        begin
            s_nxt.count = s_r.count - 1'b1;
        end
        if (rst)
        begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

endmodule

//--- verilog/cvp_bank.sv
// Calibration vector port and trim register bank behind an APB slave.
// Assumes APB with 32-bit data, synchronous reset, fuse values stable at reset.
//
// Notes on behaviour
// RULE_01: The vector port is reachable only while bit 0 of the port enable register is set.
// RULE_02: Each read of the vector register returns the next stored calibration byte.
// RULE_03: Software saves the calibration by reading the vector register 673 times in a row.
// RULE_04: A restore is 673 writes, each stored at the next vector location.
// RULE_05: Software may hold the address fixed and stream its accesses to the vector register.
// RULE_06: Software touches the vector only while calibration is halted.
// RULE_07: A save or restore cut short of 673 accesses leaves the vector marked invalid.
// RULE_08: Gain adjust A is an 8-bit read-write trim for input channel A.
// RULE_09: Gain adjust B is an 8-bit read-write trim for input channel B.
// RULE_10: The band-gap trim lives in bits 3 to 0, bits 7 to 4 are spare.
// RULE_11: Termination adjust A is an 8-bit read-write trim loaded from fuses at reset.
// RULE_12: Termination adjust B is an 8-bit read-write trim loaded from fuses at reset.
// RULE_13: All trims take their fuse values at reset instead of a fixed constant.
// RULE_14: A vector index returns to entry 0 when the port is enabled and steps per access.
// RULE_15: Low-power background calibration acts only with its enable and background mode both set.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module cvp_bank
    import cvp_pkg::*;
#(
    parameter int VLEN = cvp_pkg::VEC_LEN,
    parameter int DEPTH = cvp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cvp_pkg::ADDR_W-1:0] paddr,
    input wire logic [cvp_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [cvp_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Factory fuse values
    input wire logic [cvp_pkg::REG_W-1:0] fuse_gain_a,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_gain_b,
    input wire logic [cvp_pkg::BG_FIELD_W-1:0] fuse_bandgap,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_term_a,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_term_b,
    // Calibration engine
    input wire logic calib_halted,
    input wire logic [cvp_pkg::VEC_IDX_W-1:0] calib_vec_rd_idx,
    output logic [cvp_pkg::REG_W-1:0] calib_vec_rd_data,
    output logic calib_data_valid,
    output logic lowpower_calib_active,
    // Trim outputs
    output logic [cvp_pkg::REG_W-1:0] gain_adjust_a,
    output logic [cvp_pkg::REG_W-1:0] gain_adjust_b,
    output logic [cvp_pkg::BG_FIELD_W-1:0] bandgap_trim,
    output logic [cvp_pkg::REG_W-1:0] termination_adjust_a,
    output logic [cvp_pkg::REG_W-1:0] termination_adjust_b
);
    import cvp_pkg::*;

    localparam logic [VEC_IDX_W-1:0] VLAST = VEC_IDX_W'(VLEN - 1);
    localparam logic [VEC_IDX_W-1:0] VFULL = VEC_IDX_W'(VLEN);

    typedef struct packed {
        logic [REG_W-1:0] port_en;
        logic [REG_W-1:0] mode;
        logic [REG_W-1:0] gain_a;
        logic [REG_W-1:0] gain_b;
        logic [REG_W-1:0] bandgap;
        logic [REG_W-1:0] term_a;
        logic [REG_W-1:0] term_b;
        logic [VEC_IDX_W-1:0] idx;
        logic [VEC_IDX_W-1:0] cnt;
        logic valid;
        logic lp_active;
        logic rd_ready;
        logic [DATA_W-1:0] prdata;
        logic [REG_W-1:0] core_data;
        logic [VLEN-1:0][REG_W-1:0] vec;
    } cvp_state_t;

    cvp_state_t s_r;
    cvp_state_t s_nxt;

    cvp_stream_if #(.W(REG_W)) push_if ();
    cvp_stream_if #(.W(REG_W)) pop_if ();

    logic access;
    logic port_on;
    logic hit_vec;
    logic vec_ok;
    logic mapped;
    logic fifo_empty;
    logic wr_lane;
    logic wr_vec;
    logic done;
    logic step;
    logic pop;
    logic rd_step;
    logic refused;
    logic reg_wr;
    logic [REG_W-1:0] core_byte;
    logic [REG_W-1:0] rdval;

    //////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] i);
        return a[ADDR_W-1:2] == (ADDR_W-2)'(i);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Write FIFO in the vector restore path
    cvp_fifo #(
        .W(REG_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    //////////////////////////////////////////////////////////////////////
    // Bus decode
    assign access = psel & penable;
    assign port_on = s_r.port_en[PORT_EN_BIT];
    assign hit_vec = at(paddr, IDX_VEC);
    assign vec_ok = hit_vec & port_on; // see RULE_01
    assign fifo_empty = ~pop_if.valid;
    assign wr_lane = pwrite & pstrb[0];
    assign wr_vec = wr_lane & vec_ok;

    always_comb
    begin
        mapped = 1'b1;
        rdval = '0;
        if (at(paddr, IDX_PORT_EN))
        begin
            rdval = s_r.port_en;
        end
        else if (hit_vec)
        begin
            rdval = port_on ? s_r.vec[s_r.idx] : '0; // see RULE_02
        end
        else if (at(paddr, IDX_STATUS))
        begin
            rdval[STAT_HALTED_BIT] = calib_halted;
            rdval[STAT_VALID_BIT] = s_r.valid;
            rdval[STAT_BUSY_BIT] = ~fifo_empty;
        end
        else if (at(paddr, IDX_MODE))
        begin
            rdval = s_r.mode;
        end
        else if (at(paddr, IDX_GAIN_A))
        begin
            rdval = s_r.gain_a;
        end
        else if (at(paddr, IDX_GAIN_B))
        begin
            rdval = s_r.gain_b;
        end
        else if (at(paddr, IDX_BANDGAP))
        begin
            rdval = s_r.bandgap;
        end
        else if (at(paddr, IDX_TERM_A))
        begin
            rdval = s_r.term_a;
        end
        else if (at(paddr, IDX_TERM_B))
        begin
            rdval = s_r.term_b;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Bus answer, vector writes wait for FIFO room, other accesses for an empty FIFO
    always_comb
    begin
        if (!access)
        begin
            pready = 1'b0;
        end
        else if (pwrite)
        begin
            pready = wr_vec ? push_if.ready : fifo_empty; // see RULE_04
        end
        else
        begin
            pready = s_r.rd_ready;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Completion and refusal
    assign done = pready;
    assign refused = ~mapped | (hit_vec & ~port_on); // see RULE_01
    assign pslverr = done & refused;
    assign prdata = s_r.prdata;
    assign reg_wr = done & wr_lane & mapped;

    //////////////////////////////////////////////////////////////////////
    // FIFO feed and drain
    assign push_if.valid = access & wr_vec; // see RULE_05
    assign push_if.data = pwdata[REG_W-1:0];
    assign pop_if.ready = calib_halted; // see RULE_06
    assign pop = pop_if.valid & pop_if.ready;

    // Vector index steps on a finished read or a drained write
    assign rd_step = done & ~pwrite & vec_ok; // see RULE_02
    assign step = rd_step | pop; // see RULE_14

    //////////////////////////////////////////////////////////////////////
    // Engine side read of the stored vector, zero past the end
    always_comb
    begin
        core_byte = '0;
        if (calib_vec_rd_idx < VFULL)
        begin
            core_byte = s_r.vec[calib_vec_rd_idx];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_nxt = s_r;

        // Read data staged once the FIFO has drained
        if (psel && !pwrite && !s_r.rd_ready && fifo_empty)
        begin
            s_nxt.rd_ready = 1'b1;
            s_nxt.prdata = DATA_W'(rdval);
        end
        if (done && !pwrite)
        begin
            s_nxt.rd_ready = 1'b0;
        end

        // Restore write lands at the current index
        if (pop)
        begin
            s_nxt.vec[s_r.idx] = pop_if.data; // see RULE_04
        end

        // Index and sequence count
        if (step)
        begin
            s_nxt.idx = (s_r.idx == VLAST) ? '0 : s_r.idx + 1'b1; // see RULE_14
            if (s_r.cnt == '0)
            begin
                s_nxt.valid = 1'b0; // see RULE_07
            end
            if (s_r.cnt != VFULL)
            begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
            if (s_r.cnt == VLAST)
            begin
                s_nxt.valid = 1'b1; // see RULE_07
            end
        end

        // Register writes
        if (reg_wr)
        begin
            if (at(paddr, IDX_PORT_EN))
            begin
                s_nxt.port_en = pwdata[REG_W-1:0]; // see RULE_01
                if (pwdata[PORT_EN_BIT] && !port_on)
                begin
                    s_nxt.idx = '0; // see RULE_14
                    s_nxt.cnt = '0;
                end
            end
            if (at(paddr, IDX_MODE))
            begin
                s_nxt.mode = pwdata[REG_W-1:0];
            end
            if (at(paddr, IDX_GAIN_A))
            begin
                s_nxt.gain_a = pwdata[REG_W-1:0]; // see RULE_08
            end
            if (at(paddr, IDX_GAIN_B))
            begin
                s_nxt.gain_b = pwdata[REG_W-1:0]; // see RULE_09
            end
            if (at(paddr, IDX_BANDGAP))
            begin
                s_nxt.bandgap = pwdata[REG_W-1:0]; // see RULE_10
            end
            if (at(paddr, IDX_TERM_A))
            begin
                s_nxt.term_a = pwdata[REG_W-1:0]; // see RULE_11
            end
            if (at(paddr, IDX_TERM_B))
            begin
                s_nxt.term_b = pwdata[REG_W-1:0]; // see RULE_12
            end
        end

        // Low-power calibration needs background mode too
        s_nxt.lp_active = s_nxt.mode[MODE_LP_BIT] & s_nxt.mode[MODE_BG_BIT]; // see RULE_15

        // Engine side read of the stored vector
        s_nxt.core_data = core_byte;

        // Synchronous reset, trims from fuses
        if (rst)
        begin
            s_nxt = '0;
            s_nxt.port_en = PORT_EN_RST;
            s_nxt.mode = MODE_RST;
            s_nxt.vec = {VLEN{VEC_RST}};
            s_nxt.valid = 1'b1;
            s_nxt.gain_a = fuse_gain_a; // see RULE_13
            s_nxt.gain_b = fuse_gain_b; // see RULE_13
            s_nxt.bandgap = REG_W'(fuse_bandgap); // see RULE_13
            s_nxt.term_a = fuse_term_a; // see RULE_13
            s_nxt.term_b = fuse_term_b; // see RULE_13
        end
    end

    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

    //////////////////////////////////////////////////////////////////////
    // Outputs
    assign calib_vec_rd_data = s_r.core_data;
    assign calib_data_valid = s_r.valid;
    assign lowpower_calib_active = s_r.lp_active;
    assign gain_adjust_a = s_r.gain_a;
    assign gain_adjust_b = s_r.gain_b;
    assign bandgap_trim = s_r.bandgap[BG_FIELD_W-1:0];
    assign termination_adjust_a = s_r.term_a;
    assign termination_adjust_b = s_r.term_b;

endmodule

//--- bench/cvp_bank_assertions.sv
// Checker for the calibration port and trim bank, watching ports only.
// Assumes it is bound to cvp_bank and sees the package constants.
`timescale 1ns/1ns
module cvp_bank_assertions
    import cvp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cvp_pkg::ADDR_W-1:0] paddr,
    input wire logic [cvp_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [cvp_pkg::DATA_W-1:0] prdata,
    input wire logic pslverr,
    // Fuses
    input wire logic [cvp_pkg::REG_W-1:0] fuse_gain_a,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_gain_b,
    input wire logic [cvp_pkg::BG_FIELD_W-1:0] fuse_bandgap,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_term_a,
    input wire logic [cvp_pkg::REG_W-1:0] fuse_term_b,
    // Trims
    input wire logic [cvp_pkg::REG_W-1:0] gain_adjust_a,
    input wire logic [cvp_pkg::REG_W-1:0] gain_adjust_b,
    input wire logic [cvp_pkg::BG_FIELD_W-1:0] bandgap_trim,
    input wire logic [cvp_pkg::REG_W-1:0] termination_adjust_a,
    input wire logic [cvp_pkg::REG_W-1:0] termination_adjust_b
);
    ////////////////////////////////////////////////////////////////////////
    // Helper logic
    logic done;
    logic wr;
    logic [9:0] ix;
    logic en_r;
    assign done = psel && penable && pready;
    assign wr = done && pwrite && pstrb[0] && !pslverr;
    assign ix = paddr[11:2];
    always_ff @(posedge clk)
    begin
        if (rst)
            en_r <= 1'b0;
        else if (wr && ix == {2'h0, IDX_PORT_EN})
            en_r <= pwdata[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Properties
    property p_fuse_load;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> gain_adjust_a == $past(fuse_gain_a) && gain_adjust_b == $past(fuse_gain_b)
            && bandgap_trim == $past(fuse_bandgap) && termination_adjust_a == $past(fuse_term_a)
            && termination_adjust_b == $past(fuse_term_b);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("trim not fuse at reset");
    property p_gate_off;
        @(posedge clk) disable iff (rst)
        done && ix == {2'h0, IDX_VEC} && !en_r |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("port open while off");
    property p_gate_on;
        @(posedge clk) disable iff (rst)
        done && ix == {2'h0, IDX_VEC} && en_r |-> !pslverr;
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("port refused while on");
    property p_gain_a;
        @(posedge clk) disable iff (rst)
        wr && ix == {2'h0, IDX_GAIN_A} |=> gain_adjust_a == $past(pwdata[7:0]);
    endproperty
    a_gain_a: assert property (p_gain_a) else $error("gain a not written");
    property p_gain_b;
        @(posedge clk) disable iff (rst)
        wr && ix == {2'h0, IDX_GAIN_B} ##1 1'b1 |-> gain_adjust_b == $past(pwdata[7:0]);
    endproperty
    a_gain_b: assert property (p_gain_b) else $error("gain b not written");
    property p_bg;
        @(posedge clk) disable iff (rst)
        wr && ix == {2'h0, IDX_BANDGAP} |=> bandgap_trim == $past(pwdata[3:0]);
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap field not written");
    property p_term_a;
        @(posedge clk) disable iff (rst)
        wr && ix == {2'h0, IDX_TERM_A} |=> termination_adjust_a == $past(pwdata[7:0]);
    endproperty
    a_term_a: assert property (p_term_a) else $error("term a not written");
    property p_term_b;
        @(posedge clk) disable iff (rst)
        wr && ix == {2'h0, IDX_TERM_B} |=> termination_adjust_b == $past(pwdata[7:0]);
    endproperty
    a_term_b: assert property (p_term_b) else $error("term b not written");
endmodule

bind cvp_bank cvp_bank_assertions u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .fuse_gain_a, .fuse_gain_b, .fuse_bandgap, .fuse_term_a,
    .fuse_term_b, .gain_adjust_a, .gain_adjust_b, .bandgap_trim, .termination_adjust_a,
    .termination_adjust_b);

//--- bench/cvp_bank_tb.sv
// Self-checking bench for the calibration port and trim bank.
// Assumes cvp_bank with default parameters and an APB master here.
`timescale 1ns/1ns
module cvp_bank_tb;
    import cvp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, rerr, calib_data_valid, lowpower_calib_active;
    logic [DATA_W-1:0] prdata, rdat;
    logic [7:0] fuse_gain_a, fuse_gain_b, fuse_term_a, fuse_term_b, calib_vec_rd_data;
    logic [7:0] gain_adjust_a, gain_adjust_b, termination_adjust_a, termination_adjust_b;
    logic [3:0] fuse_bandgap, bandgap_trim;
    logic calib_halted = 1'b1;
    logic [9:0] calib_vec_rd_idx = 10'h0;
    int n_errors = 0;
    int samples_checked = 0;
    int waits;
    logic [7:0] vec[VEC_LEN];
    logic [7:0] tv[5];
    logic [7:0] ti[5] = '{IDX_GAIN_A, IDX_GAIN_B, IDX_BANDGAP, IDX_TERM_A, IDX_TERM_B};
    wire [39:0] tout = {termination_adjust_b, termination_adjust_a, 4'h0, bandgap_trim,
        gain_adjust_b, gain_adjust_a};

    cvp_bank u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .prdata, .pslverr, .fuse_gain_a, .fuse_gain_b, .fuse_bandgap, .fuse_term_a, .fuse_term_b,
        .calib_halted, .calib_vec_rd_idx, .calib_vec_rd_data, .calib_data_valid,
        .lowpower_calib_active, .gain_adjust_a, .gain_adjust_b, .bandgap_trim,
        .termination_adjust_a, .termination_adjust_b);

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Tasks and expectations
    function automatic logic [7:0] exp_trim(int k, logic [7:0] v);
        return (k == 2) ? {4'h0, v[3:0]} : v;
    endfunction

    task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
        waits = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            waits++;
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #3000000;
        n_errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        int i;
        int p;
        int k;
        logic [7:0] v;
        void'($urandom(62308));
        fuse_gain_a = $urandom;
        fuse_gain_b = $urandom;
        fuse_bandgap = $urandom;
        fuse_term_a = $urandom;
        fuse_term_b = $urandom;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tv = '{fuse_gain_a, fuse_gain_b, {4'h0, fuse_bandgap}, fuse_term_a, fuse_term_b};
        for (i = 0; i < 5; i++)
        begin
            apb(1'b0, ti[i], 32'h0);
            chk(rdat, {24'h0, tv[i]});
            v = i[0] ? 8'hFF : 8'($urandom);
            apb(1'b1, ti[i], {24'h0, v});
            apb(1'b0, ti[i], 32'h0);
            chk(rdat, {24'h0, v});
            chk({24'h0, tout[i*8 +: 8]}, {24'h0, exp_trim(i, v)});
        end
        apb(1'b0, 8'h7D, 32'h0);
        chkb(rerr, 1'b1);
        apb(1'b0, IDX_VEC, 32'h0);
        chkb(rerr, 1'b1);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, IDX_MODE, i);
            @(negedge clk);
            chkb(lowpower_calib_active, i == 3);
        end
        $display("registers done");
        apb(1'b1, IDX_PORT_EN, 32'h1);
        fork
        begin
            @(posedge clk);
            calib_halted <= 1'b0;
            repeat (60) @(posedge clk);
            calib_halted <= 1'b1;
        end
        join_none
        for (i = 0; i < VEC_LEN; i++)
        begin
            vec[i] = $urandom;
            apb(1'b1, IDX_VEC, {24'h0, vec[i]});
            chkb(rerr, 1'b0);
            if (i == 8)
                chkb(waits > 8, 1'b1);
        end
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rdat, 32'h3);
        for (i = 0; i < 20; i++)
        begin
            k = (i == 0) ? VEC_LEN - 1 : $urandom_range(VEC_LEN - 1);
            @(posedge clk);
            calib_vec_rd_idx <= k[9:0];
            repeat (2) @(negedge clk);
            chk({24'h0, calib_vec_rd_data}, {24'h0, vec[k]});
        end
        $display("restore done");
        for (p = 0; p < 2; p++)
        begin
            apb(1'b1, IDX_PORT_EN, 32'h0);
            apb(1'b1, IDX_PORT_EN, 32'h1);
            for (i = 0; i < (p ? VEC_LEN : 5); i++)
            begin
                apb(1'b0, IDX_VEC, 32'h0);
                chk(rdat, {24'h0, vec[i]});
            end
            apb(1'b1, IDX_PORT_EN, 32'h0);
            chkb(calib_data_valid, p[0]);
        end
        $display("save done");
        final_report();
    end
endmodule
